// >>> wdt_cfg_pkg.sv
// Package for the watchdog configuration block: register map and fields
package wdt_cfg_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] CFG_ADDR    = 8'h00;
  localparam logic [7:0] CTRL_ADDR   = 8'h04;
  localparam logic [7:0] STAT_ADDR   = 8'h08;
  localparam logic [7:0] MASK_ADDR   = 8'h0C;
  localparam logic [7:0] COUNT_ADDR  = 8'h10;
  localparam logic [23:0] CFG_WORD_OFFSET = 24'h30_0004;

  // ----------------------------------------------------------------------
  // Configuration byte fields
  // ----------------------------------------------------------------------
  localparam int MODE_HI     = 6;
  localparam int MODE_LO     = 5;
  localparam int PERIOD_HI   = 4;
  localparam int PERIOD_LO   = 0;
  localparam int UNIMPL_BIT  = 7;
  localparam logic [7:0] CFG_BLANK = 8'hFF;

  // Control register: bit 0 software enable, bit 1 clear (write only)
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_CLR_BIT = 1;

  // Status bits
  localparam int ST_TIMEOUT   = 0;
  localparam int ST_WIDTH     = 1;

  // ----------------------------------------------------------------------
  // Period select
  // ----------------------------------------------------------------------
  localparam int          PERIOD_BASE_LOG2 = 5;
  localparam logic [4:0]  PERIOD_MAX_SEL   = 5'h12;
  localparam logic [4:0]  PERIOD_FALLBACK  = 5'h0B;
  localparam int          COUNT_W          = 24;

  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_SOFTWARE,
    MODE_AWAKE,
    MODE_ALWAYS
  } wdt_mode_t;

endpackage : wdt_cfg_pkg

// >>> wdt_cfg_top.sv
// Watchdog with configuration-word mode and period select, Wishbone slave
// ------------------------------------------------------------------------
// Summary of operation
// ------------------------------------------------------------------------
// Summary of operation
// - Mode bits 6:5, period bits 4:0
// - Mode 00: watchdog off, enable ignored
// - Mode 01: runs exactly while software enable set
// - Mode 10: runs awake, stopped and count cleared in sleep
// - Mode 11: runs always, enable ignored
// - Period n up to 18 gives divide by two^(5+n)
// - Bit 7 reads as one
// - Blank default: always mode, period all ones
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ns
module wdt_cfg_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic              CLK,
  input  wire logic              RSTN,
  // Wishbone register bus
  input  wire logic              WB_CYC_I,
  input  wire logic              WB_STB_I,
  input  wire logic              WB_WE_I,
  input  wire logic [ADDR_W-1:0] WB_ADR_I,
  input  wire logic [3:0]        WB_SEL_I,
  input  wire logic [31:0]       WB_DAT_I,
  output      logic [31:0]       WB_DAT_O,
  output      logic              WB_ACK_O,
  // Watchdog time base and core state
  input  wire logic              LF_TICK,
  input  wire logic              CORE_SLEEP,
  // Results
  output      logic              WDT_RESET_REQ,
  output      logic              IRQ
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (ADDR_W < 8) begin : g_chk
    $error("ADDR_W must be at least 8");
  end

  // The counter must reach the terminal count of the longest period
  localparam int TERM_MSB = wdt_cfg_pkg::PERIOD_BASE_LOG2
                            + int'(wdt_cfg_pkg::PERIOD_MAX_SEL);
  if (wdt_cfg_pkg::COUNT_W <= TERM_MSB) begin : g_chk_count
    $error("COUNT_W too small for the longest period");
  end

  // The count is read back in one bus word
  if (wdt_cfg_pkg::COUNT_W > 32) begin : g_chk_cw
    $error("COUNT_W must fit a bus word");
  end

  // The decode below takes the mode field as exactly two bits
  if (wdt_cfg_pkg::MODE_HI - wdt_cfg_pkg::MODE_LO != 1) begin : g_chk_mode
    $error("Mode field must be two bits wide");
  end

  if (wdt_cfg_pkg::PERIOD_HI - wdt_cfg_pkg::PERIOD_LO != 4) begin : g_chk_per
    $error("Period field must be five bits wide");
  end

  // The stored byte is seven bits under the always-one top bit
  if (wdt_cfg_pkg::UNIMPL_BIT != wdt_cfg_pkg::MODE_HI + 1) begin : g_chk_top
    $error("Unimplemented bit must sit above the mode field");
  end

  if (wdt_cfg_pkg::ST_TIMEOUT >= wdt_cfg_pkg::ST_WIDTH) begin : g_chk_stat
    $error("Timeout flag lies outside the status register");
  end

  if (wdt_cfg_pkg::CTRL_EN_BIT == wdt_cfg_pkg::CTRL_CLR_BIT) begin : g_chk_ctl
    $error("Enable and clear must be separate control bits");
  end

  // The all-ones code must fall back to a ratio the counter supports
  localparam bit FB_BAD = wdt_cfg_pkg::PERIOD_FALLBACK
                          > wdt_cfg_pkg::PERIOD_MAX_SEL;
  if (FB_BAD) begin : g_chk_fb
    $error("Fallback period beyond the longest ratio");
  end

  // A blank part must come up in the always-running mode
  localparam logic [1:0] BLANK_MODE =
      wdt_cfg_pkg::CFG_BLANK[wdt_cfg_pkg::MODE_HI:wdt_cfg_pkg::MODE_LO];
  if (BLANK_MODE != wdt_cfg_pkg::MODE_ALWAYS) begin : g_chk_blank
    $error("Blank default must select the always mode");
  end

  localparam logic [7:0] REG_ADDRS [5] = '{wdt_cfg_pkg::CFG_ADDR,
                                           wdt_cfg_pkg::CTRL_ADDR,
                                           wdt_cfg_pkg::STAT_ADDR,
                                           wdt_cfg_pkg::MASK_ADDR,
                                           wdt_cfg_pkg::COUNT_ADDR};

  // Each register needs its own word-aligned address
  for (genvar r = 0; r < 5; r++) begin : g_chk_addr
    if (REG_ADDRS[r][1:0] != 2'b00) begin : g_align
      $error("Register address not word aligned");
    end
    for (genvar s = r + 1; s < 5; s++) begin : g_uniq
      if (REG_ADDRS[r] == REG_ADDRS[s]) begin : g_dup
        $error("Two registers share an address");
      end
    end
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [6:0]                       cfg;
    logic                             sw_en;
    logic [wdt_cfg_pkg::COUNT_W-1:0]  count;
    logic [wdt_cfg_pkg::ST_WIDTH-1:0] status;
    logic [wdt_cfg_pkg::ST_WIDTH-1:0] mask;
    logic                             rst_req;
    logic                             ack;
    logic [31:0]                      rdata;
  } state_t;

  state_t state_reg;
  state_t state_next;

  wdt_cfg_pkg::wdt_mode_t mode;
  logic [4:0]             period_sel;
  logic [4:0]             period_eff;
  logic                   running;
  logic                   clear_req;
  logic                   timeout;
  logic                   wr_strobe;
  logic                   rd_strobe;
  logic                   lane0;
  logic [7:0]             addr;
  logic [7:0]             cfg_read;
  logic [wdt_cfg_pkg::COUNT_W-1:0] terminal;

  // ----------------------------------------------------------------------
  // Bus strobes
  // ----------------------------------------------------------------------
  assign addr      = WB_ADR_I[7:0];
  assign lane0     = WB_SEL_I[0];
  // Answer one cycle after the request, then drop ack for a cycle
  assign wr_strobe = WB_CYC_I && WB_STB_I && WB_WE_I && !state_reg.ack;
  assign rd_strobe = WB_CYC_I && WB_STB_I && !WB_WE_I && !state_reg.ack;

  // ----------------------------------------------------------------------
  // Register selects
  // ----------------------------------------------------------------------
  // Register map, one 32-bit word each, data in the low bits:
  //   config  mode and period byte, top bit always reads one
  //   control bit 0 software enable, bit 1 write one to service
  //   status  bit 0 timeout, sticky, write one to clear
  //   mask    bit 0 lets the timeout flag drive the interrupt
  //   counter current count in low-frequency ticks, read only
  // Only byte lane 0 carries writable bits; a write without it is dropped
  logic cfg_hit;
  logic ctrl_hit;
  logic stat_hit;
  logic mask_hit;
  logic count_hit;
  logic lane_wr;
  logic cfg_wr;
  logic ctrl_wr;
  logic stat_wr;
  logic mask_wr;

  assign cfg_hit   = addr == wdt_cfg_pkg::CFG_ADDR;
  assign ctrl_hit  = addr == wdt_cfg_pkg::CTRL_ADDR;
  assign stat_hit  = addr == wdt_cfg_pkg::STAT_ADDR;
  assign mask_hit  = addr == wdt_cfg_pkg::MASK_ADDR;
  assign count_hit = addr == wdt_cfg_pkg::COUNT_ADDR;
  assign lane_wr   = wr_strobe && lane0;
  assign cfg_wr    = lane_wr && cfg_hit;
  assign ctrl_wr   = lane_wr && ctrl_hit;
  assign stat_wr   = lane_wr && stat_hit;
  assign mask_wr   = lane_wr && mask_hit;

  // ----------------------------------------------------------------------
  // Mode and period decode
  // ----------------------------------------------------------------------
  assign mode = wdt_cfg_pkg::wdt_mode_t'(
      state_reg.cfg[wdt_cfg_pkg::MODE_HI:wdt_cfg_pkg::MODE_LO]);
  assign period_sel =
      state_reg.cfg[wdt_cfg_pkg::PERIOD_HI:wdt_cfg_pkg::PERIOD_LO];

  // Reserved codes above the last ratio: all ones falls to the blank-part
  // default, the rest fall to the shortest ratio.
  always_comb begin
    if (period_sel <= wdt_cfg_pkg::PERIOD_MAX_SEL) begin
      period_eff = period_sel;
    end else if (period_sel == 5'h1F) begin
      period_eff = wdt_cfg_pkg::PERIOD_FALLBACK;
    end else begin
      period_eff = 5'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Terminal count
  // ----------------------------------------------------------------------
  always_comb begin
    terminal = '0;
    terminal[5'(wdt_cfg_pkg::PERIOD_BASE_LOG2) + period_eff] = 1'b1;
  end

  // ----------------------------------------------------------------------
  // Run enable by mode
  // ----------------------------------------------------------------------
  always_comb begin
    unique case (mode)
      wdt_cfg_pkg::MODE_OFF: begin
        running = 1'b0;
      end
      wdt_cfg_pkg::MODE_SOFTWARE: begin
        running = state_reg.sw_en;
      end
      wdt_cfg_pkg::MODE_AWAKE: begin
        // A sleep period restarts the count from zero on wake
        running = !CORE_SLEEP;
      end
      wdt_cfg_pkg::MODE_ALWAYS: begin
        running = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Service and timeout
  // ----------------------------------------------------------------------
  assign clear_req = ctrl_wr && WB_DAT_I[wdt_cfg_pkg::CTRL_CLR_BIT];
  // The tick that brings the count to the divider ratio is the timeout
  assign timeout   = running && LF_TICK && !clear_req
                     && (state_reg.count + 1'b1 >= terminal);

  assign cfg_read = {1'b1, state_reg.cfg};

  // ----------------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------------
  logic [wdt_cfg_pkg::ST_WIDTH-1:0] st_event;
  logic [wdt_cfg_pkg::ST_WIDTH-1:0] st_clr;
  logic [wdt_cfg_pkg::ST_WIDTH-1:0] st_upd;

  always_comb begin
    st_event                          = '0;
    st_event[wdt_cfg_pkg::ST_TIMEOUT] = timeout;
  end

  assign st_clr = stat_wr ? WB_DAT_I[wdt_cfg_pkg::ST_WIDTH-1:0] : '0;

  // A flag set by hardware in the cycle of a write-one clear stays set,
  // so software never loses an event it has not yet seen
  for (genvar b = 0; b < wdt_cfg_pkg::ST_WIDTH; b++) begin : g_status
    assign st_upd[b] = st_event[b] || (state_reg.status[b] && !st_clr[b]);
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    if (cfg_hit) begin
      rd_word[7:0] = cfg_read;
    end
    if (ctrl_hit) begin
      // The clear bit is an action, not state, and reads as zero
      rd_word[wdt_cfg_pkg::CTRL_EN_BIT] = state_reg.sw_en;
    end
    if (stat_hit) begin
      rd_word[wdt_cfg_pkg::ST_WIDTH-1:0] = state_reg.status;
    end
    if (mask_hit) begin
      rd_word[wdt_cfg_pkg::ST_WIDTH-1:0] = state_reg.mask;
    end
    if (count_hit) begin
      rd_word[wdt_cfg_pkg::COUNT_W-1:0] = state_reg.count;
    end
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    state_next        = state_reg;
    state_next.ack    = rd_strobe || wr_strobe;
    state_next.rdata  = rd_strobe ? rd_word : 32'h0000_0000;
    state_next.status = st_upd;

    // Counter advances on each low-frequency tick; a service in
    // the timeout tick wins, so a late but valid service never resets
    if (clear_req || !running) begin
      state_next.count = '0;
    end else if (timeout) begin
      state_next.count   = '0;
      state_next.rst_req = 1'b1;
    end else if (LF_TICK) begin
      state_next.count = state_reg.count + 1'b1;
    end

    // Servicing also withdraws a pending reset request
    if (clear_req) begin
      state_next.rst_req = 1'b0;
    end

    if (cfg_wr) begin
      // Writable here so the programmed word can be modelled
      state_next.cfg = WB_DAT_I[wdt_cfg_pkg::UNIMPL_BIT-1:0];
    end

    if (ctrl_wr) begin
      state_next.sw_en = WB_DAT_I[wdt_cfg_pkg::CTRL_EN_BIT];
    end

    if (mask_wr) begin
      state_next.mask = WB_DAT_I[wdt_cfg_pkg::ST_WIDTH-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg         <= '0;
      // The word is kept in flops, so every reset brings back the blank
      // default; a programmed value lasts only until the next reset
      state_reg.cfg     <= wdt_cfg_pkg::CFG_BLANK[6:0];
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign WB_ACK_O      = state_reg.ack;
  assign WB_DAT_O      = state_reg.rdata;
  assign WDT_RESET_REQ = state_reg.rst_req;
  assign IRQ           = |(state_reg.status & state_reg.mask);

endmodule : wdt_cfg_top

// >>> wdt_cfg_top_monitor.sv
// Checker of bus handshake and reset request behaviour
`timescale 1ns/1ns
module wdt_monitor #(
  parameter int ADDR_W = 8
) (
  input wire logic              CLK,
  input wire logic              RSTN,
  input wire logic              WB_CYC_I,
  input wire logic              WB_STB_I,
  input wire logic              WB_WE_I,
  input wire logic [ADDR_W-1:0] WB_ADR_I,
  input wire logic [3:0]        WB_SEL_I,
  input wire logic [31:0]       WB_DAT_I,
  input wire logic [31:0]       WB_DAT_O,
  input wire logic              WB_ACK_O,
  input wire logic              LF_TICK,
  input wire logic              WDT_RESET_REQ,
  input wire logic              IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  sequence s_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  a_ack_next: assert property (s_req |=> WB_ACK_O)
    else $error("ack missing");
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack too long");
  a_ack_cause: assert property ($rose(WB_ACK_O) |-> $past(WB_STB_I))
    else $error("ack without request");
  a_dat_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0000_0000)
    else $error("data outside read");
  a_cfg_top: assert property (WB_ACK_O && !WB_WE_I &&
    WB_ADR_I == wdt_cfg_pkg::CFG_ADDR |-> WB_DAT_O[7])
    else $error("config bit 7 low");
  a_req_tick: assert property ($rose(WDT_RESET_REQ) |-> $past(LF_TICK))
    else $error("request without tick");
  a_req_hold: assert property ($fell(WDT_RESET_REQ) |->
    $past(WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && WB_SEL_I[0] &&
    WB_ADR_I == wdt_cfg_pkg::CTRL_ADDR &&
    WB_DAT_I[wdt_cfg_pkg::CTRL_CLR_BIT]))
    else $error("request dropped without a clear");
  a_irq_cause: assert property ($rose(IRQ) |-> $past(LF_TICK) ||
    $past(WB_STB_I))
    else $error("irq without cause");
endmodule : wdt_monitor
bind wdt_cfg_top wdt_monitor #(.ADDR_W(ADDR_W)) wdt_monitor_i (
  .CLK(CLK), .RSTN(RSTN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O),
  .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
  .WB_ACK_O(WB_ACK_O), .LF_TICK(LF_TICK),
  .WDT_RESET_REQ(WDT_RESET_REQ), .IRQ(IRQ));

// >>> tb.sv
// Self-checking bench for the watchdog configuration block
`timescale 1ns/1ns
module tb;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  sel = 4'hF;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dwr = 32'h0000_0000;
  logic        tick = 1'b0;
  logic        slp = 1'b0;
  logic [31:0] drd;
  logic [31:0] q;
  logic        ack;
  logic        req;
  logic        irq;
  logic [1:0]  m;
  logic [4:0]  n;
  int          n_errors = 0;
  int          comparisons = 0;

  always #20 clk = ~clk;

  wdt_cfg_top wdt_cfg_top_i (
    .CLK(clk), .RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dwr),
    .WB_DAT_O(drd), .WB_ACK_O(ack), .LF_TICK(tick),
    .CORE_SLEEP(slp), .WDT_RESET_REQ(req), .IRQ(irq));

  task automatic give_verdict;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // Request is held until ack is seen at a rising edge, then released
  task automatic wb(input logic w, input logic [7:0] a, input int d);
    int i;
    @(posedge clk);
    {cyc, stb, we, adr, dwr} <= {2'b11, w, a, d};
    for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge clk);
    if (ack !== 1'b1) begin
      n_errors++;
      give_verdict();
    end
    q = drd;
    {cyc, stb} <= 2'b00;
  endtask : wb

  // One idle cycle after each tick so every pulse lasts exactly one cycle
  task automatic ticks(input int k);
    repeat (k) begin
      @(posedge clk) tick <= 1'b1;
      @(posedge clk) tick <= 1'b0;
    end
    @(posedge clk);
  endtask : ticks

  function automatic int runs(input logic [1:0] md, input int k);
    return md == 2'b11 || (md == 2'b10 && !k[1]) || (md == 2'b01 && k[0]);
  endfunction : runs

  function automatic int lim(input logic [4:0] p);
    return p <= 5'h12 ? 1 << (5 + p) : (p == 5'h1F ? 65536 : 32);
  endfunction : lim

  initial begin
    void'($urandom(56));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    wb(0, wdt_cfg_pkg::CFG_ADDR, 0);
    chk(q, 32'h0000_00FF);
    wb(1, 8'h20, -1);
    wb(0, 8'h20, 0);
    chk(q, 32'h0000_0000);
    for (int k = 0; k < 16; k++) begin
      m = k[3:2];
      wb(1, wdt_cfg_pkg::CFG_ADDR, {25'h0, m, 5'h02});
      wb(0, wdt_cfg_pkg::CFG_ADDR, 0);
      chk(q, {24'h0, 1'b1, m, 5'h02});
      slp <= k[1];
      wb(1, wdt_cfg_pkg::CTRL_ADDR, 2 + k[0]);
      ticks(3);
      wb(0, wdt_cfg_pkg::COUNT_ADDR, 0);
      chk(q, runs(m, k) * 3);
    end
    slp <= 1'b0;
    sel <= 4'hE;
    wb(1, wdt_cfg_pkg::MASK_ADDR, 1);
    sel <= 4'hF;
    wb(0, wdt_cfg_pkg::MASK_ADDR, 0);
    chk(q, 0);
    for (int i = 0; i < 4; i++) begin
      n = (i == 3) ? 5'h13 : 5'($urandom % 3);
      wb(1, wdt_cfg_pkg::MASK_ADDR, i[0]);
      wb(1, wdt_cfg_pkg::CFG_ADDR, {25'h0, 2'b11, n});
      wb(1, wdt_cfg_pkg::CTRL_ADDR, 2);
      ticks(lim(n) - 1);
      chk(req, 0);
      ticks(1);
      chk({req, irq}, {1'b1, i[0]});
      wb(0, wdt_cfg_pkg::STAT_ADDR, 0);
      chk(q, 1);
      wb(1, wdt_cfg_pkg::STAT_ADDR, 1);
      chk(irq, 0);
      wb(1, wdt_cfg_pkg::CTRL_ADDR, 2);
      chk(req, 0);
    end
    give_verdict();
  end
endmodule : tb
